// *** itc_pkg.sv ***
// Package: register map, field positions and constants of the I2C timeout counter
package itc_pkg;
    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  CLOCK_RATE_INDEX    = 8'hbe;
    localparam logic [7:0]  TIMEOUT_CTRL_INDEX  = 8'hbf;
    localparam logic [7:0]  SERIAL_CTRL_INDEX   = 8'hc0;
    localparam int          ADDR_W              = 12;
    localparam logic [11:0] CLOCK_RATE_ADDR     = {2'h0, CLOCK_RATE_INDEX, 2'h0};
    localparam logic [11:0] TIMEOUT_CTRL_ADDR   = {2'h0, TIMEOUT_CTRL_INDEX, 2'h0};
    localparam logic [11:0] SERIAL_CTRL_ADDR    = {2'h0, SERIAL_CTRL_INDEX, 2'h0};
    localparam logic [11:0] IRQ_STATUS_ADDR     = 12'h310;
    localparam logic [11:0] IRQ_MASK_ADDR       = 12'h314;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TO_OVERFLOW_BIT   = 0;
    localparam int TO_QUARTER_BIT    = 1;
    localparam int TO_ENABLE_BIT     = 2;
    localparam int SC_EVENT_BIT      = 3;
    localparam int SC_ENABLE_BIT     = 6;
    localparam int IRQ_OVERFLOW_BIT  = 0;
    localparam int IRQ_EVENT_BIT     = 1;
    localparam int IRQ_W             = 2;

    // ------------------------------------------------------------
    // Reset values and counter constants
    // ------------------------------------------------------------
    localparam logic [7:0]  CLOCK_RATE_RESET    = 8'h00;
    localparam logic [1:0]  IRQ_MASK_RESET      = 2'h0;
    localparam int          COUNT_W             = 14;
    localparam logic [13:0] COUNT_MAX           = 14'h3fff;
    localparam logic [13:0] COUNT_ONE           = 14'h0001;
    localparam logic [1:0]  QUARTER_LAST        = 2'h3;
    localparam logic [1:0]  PRESCALE_ONE        = 2'h1;
    localparam logic [7:0]  IDLE_STATUS_CODE    = 8'hf8;
    localparam logic [7:0]  TIMEOUT_CTRL_MASK   = 8'h07;
endpackage : itc_pkg

// *** itc_timeout_counter.sv ***
// Design: I2C bus timeout counter with APB register access and interrupt
//
// Contract
// - An 8-bit clock-rate register sets the serial clock rate.
// - Counter stays idle while its enable bit (bit 2) is zero.
// - Counter counts only when counter enable and serial function enable are set.
// - Serial event flag set stops the counter and clears it to zero.
// - Bit 1 zero counts every clock; one counts every fourth clock.
// - Overflow of the 14-bit counter sets bit 0; zero until overflow.
// - Set overflow flag raises the I2C interrupt when enabled.
// - Engine sets the serial event flag on each new status code except idle.
// - Serial function enable bit 6 enables function; zero tri-states bus outputs.
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
module itc_timeout_counter
    import itc_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [itc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  statusStrobe,
    input  wire logic [7:0]            statusCode,
    input  wire logic                  sclDriveLow,
    input  wire logic                  sdaDriveLow,
    output logic                       sclOut,
    output logic                       sclOe,
    output logic                       sdaOut,
    output logic                       sdaOe,
    output logic [7:0]                 serialClockRate,
    output logic                       serialFunctionEnable,
    output logic                       irq
);
    import itc_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        regHit = (a == r);
    endfunction : regHit

    logic                 apbSetup;
    logic                 apbWrite;
    logic                 mapped;
    logic                 wrRate;
    logic                 wrTimeout;
    logic                 wrSerial;
    logic                 wrIrqStatus;
    logic                 wrIrqMask;

    assign apbSetup    = psel && !penable;
    assign apbWrite    = psel && penable && pwrite;
    assign mapped      = regHit(paddr, CLOCK_RATE_ADDR) || regHit(paddr, TIMEOUT_CTRL_ADDR)
                      || regHit(paddr, SERIAL_CTRL_ADDR) || regHit(paddr, IRQ_STATUS_ADDR)
                      || regHit(paddr, IRQ_MASK_ADDR);
    assign wrRate      = apbWrite && regHit(paddr, CLOCK_RATE_ADDR);
    assign wrTimeout   = apbWrite && regHit(paddr, TIMEOUT_CTRL_ADDR);
    assign wrSerial    = apbWrite && regHit(paddr, SERIAL_CTRL_ADDR);
    assign wrIrqStatus = apbWrite && regHit(paddr, IRQ_STATUS_ADDR);
    assign wrIrqMask   = apbWrite && regHit(paddr, IRQ_MASK_ADDR);

    // Always ready; data is staged in the setup cycle so the answer is a flop
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // Registers and counter state
    // ------------------------------------------------------------
    logic [7:0]         rateReg,      rateNext;
    logic               enableReg,    enableNext;
    logic               quarterReg,   quarterNext;
    logic               overflowReg,  overflowNext;
    logic               ensiReg,      ensiNext;
    logic               eventReg,     eventNext;
    logic [IRQ_W-1:0]   irqStatReg,   irqStatNext;
    logic [IRQ_W-1:0]   irqMaskReg,   irqMaskNext;
    logic [COUNT_W-1:0] countReg,     countNext;
    logic [1:0]         prescaleReg,  prescaleNext;
    logic [31:0]        prdataReg,    prdataNext;
    logic               run;
    logic               tick;
    logic               overflowHit;
    logic               eventSet;

    // Counting needs both enables and no pending serial event
    assign run = enableReg && ensiReg && !eventReg;
    // Quarter rate uses a prescaler enable, never a derived clock
    assign tick = run && (!quarterReg || prescaleReg == QUARTER_LAST);
    assign overflowHit = tick && countReg == COUNT_MAX;
    assign eventSet = statusStrobe && statusCode != IDLE_STATUS_CODE;

    always_comb begin
        rateNext     = rateReg;
        enableNext   = enableReg;
        quarterNext  = quarterReg;
        overflowNext = overflowReg;
        ensiNext     = ensiReg;
        eventNext    = eventReg;
        irqMaskNext  = irqMaskReg;
        irqStatNext  = irqStatReg;
        countNext    = countReg;
        prescaleNext = prescaleReg;
        if (wrRate) begin
            rateNext = pwdata[7:0];
        end
        if (wrTimeout) begin
            enableNext  = pwdata[TO_ENABLE_BIT];
            quarterNext = pwdata[TO_QUARTER_BIT];
            // Only a written zero clears the flag; writing one leaves it alone
            if (!pwdata[TO_OVERFLOW_BIT]) begin
                overflowNext = 1'b0;
            end
        end
        if (wrSerial) begin
            ensiNext = pwdata[SC_ENABLE_BIT];
            if (!pwdata[SC_EVENT_BIT]) begin
                eventNext = 1'b0;
            end
        end
        if (wrIrqMask) begin
            irqMaskNext = pwdata[IRQ_W-1:0];
        end
        if (wrIrqStatus) begin
            irqStatNext = irqStatReg & ~pwdata[IRQ_W-1:0];
        end
        // Hardware sets win over a software clear in the same cycle
        if (eventSet) begin
            eventNext = 1'b1;
            irqStatNext[IRQ_EVENT_BIT] = 1'b1;
        end
        if (overflowHit) begin
            overflowNext = 1'b1;
            irqStatNext[IRQ_OVERFLOW_BIT] = 1'b1;
        end
        if (eventReg) begin
            countNext    = '0;
            prescaleNext = '0;
        end else if (run) begin
            prescaleNext = prescaleReg + PRESCALE_ONE;
            if (tick) begin
                countNext = countReg + COUNT_ONE;
            end
        end else begin
            prescaleNext = '0;
        end
    end

    always_comb begin
        prdataNext = prdataReg;
        if (apbSetup) begin
            prdataNext = '0;
            if (regHit(paddr, CLOCK_RATE_ADDR)) begin
                prdataNext[7:0] = rateReg;
            end else if (regHit(paddr, TIMEOUT_CTRL_ADDR)) begin
                // Upper bits stay zero
                prdataNext[TO_ENABLE_BIT]   = enableReg;
                prdataNext[TO_QUARTER_BIT]  = quarterReg;
                prdataNext[TO_OVERFLOW_BIT] = overflowReg;
            end else if (regHit(paddr, SERIAL_CTRL_ADDR)) begin
                prdataNext[SC_ENABLE_BIT] = ensiReg;
                prdataNext[SC_EVENT_BIT]  = eventReg;
            end else if (regHit(paddr, IRQ_STATUS_ADDR)) begin
                prdataNext[IRQ_W-1:0] = irqStatReg;
            end else if (regHit(paddr, IRQ_MASK_ADDR)) begin
                prdataNext[IRQ_W-1:0] = irqMaskReg;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rateReg     <= CLOCK_RATE_RESET;
            enableReg   <= 1'b0;
            quarterReg  <= 1'b0;
            overflowReg <= 1'b0;
            ensiReg     <= 1'b0;
            eventReg    <= 1'b0;
            irqStatReg  <= '0;
            irqMaskReg  <= IRQ_MASK_RESET;
            countReg    <= '0;
            prescaleReg <= '0;
            prdataReg   <= '0;
        end else begin
            rateReg     <= rateNext;
            enableReg   <= enableNext;
            quarterReg  <= quarterNext;
            overflowReg <= overflowNext;
            ensiReg     <= ensiNext;
            eventReg    <= eventNext;
            irqStatReg  <= irqStatNext;
            irqMaskReg  <= irqMaskNext;
            countReg    <= countNext;
            prescaleReg <= prescaleNext;
            prdataReg   <= prdataNext;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata               = prdataReg;
    assign serialClockRate      = rateReg;
    assign serialFunctionEnable = ensiReg;
    assign irq                  = |(irqStatReg & irqMaskReg);
    // Open-drain pins: released entirely while the function is off
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe  = ensiReg && sclDriveLow;
    assign sdaOe  = ensiReg && sdaDriveLow;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence quarterTick;
        tick && quarterReg && run;
    endsequence

    sequence quarterGap;
        !tick [*3];
    endsequence

    rate_write_a: assert property (wrRate |=> serialClockRate == $past(pwdata[7:0]))
        else $error("clock rate register did not take write");

    count_idle_a: assert property (!enableReg && !eventReg |=> $stable(countReg))
        else $error("counter moved while disabled");

    count_gate_a: assert property (tick |-> enableReg && ensiReg)
        else $error("counter advanced without both enables");

    count_inc_a: assert property (tick |=> countReg == $past(countReg) + COUNT_ONE)
        else $error("counter did not advance by one");

    event_clear_a: assert property (eventReg |-> !tick ##1 countReg == '0)
        else $error("serial event did not stop and clear counter");

    full_rate_a: assert property (run && !quarterReg |-> tick)
        else $error("full rate missed a count");

    quarter_rate_a: assert property (quarterTick ##1 (run && quarterReg) |-> quarterGap)
        else $error("quarter rate ticked too soon");

    overflow_set_a: assert property (overflowHit |=> overflowReg && countReg == '0)
        else $error("overflow flag not set on wrap");

    overflow_hold_a: assert property (overflowReg && !wrTimeout |=> overflowReg)
        else $error("overflow flag cleared by hardware");

    irq_raise_a: assert property (overflowHit && irqMaskReg[IRQ_OVERFLOW_BIT] |=> irq)
        else $error("overflow did not raise interrupt");

    event_set_a: assert property (eventSet |=> eventReg)
        else $error("new status code did not set event flag");

    idle_code_a: assert property (statusStrobe && !eventSet && !eventReg |=> !eventReg)
        else $error("idle status code set event flag");

    bus_release_a: assert property (!ensiReg |-> !sclOe && !sdaOe)
        else $error("bus driven while serial function disabled");

    reserved_zero_a: assert property (apbSetup && regHit(paddr, TIMEOUT_CTRL_ADDR)
                                      |=> prdata[31:3] == '0)
        else $error("reserved timeout control bits read nonzero");

endmodule : itc_timeout_counter

// *** tb_itc_timeout_counter.sv ***
// Testbench: register, event, interrupt and counter checks of the timeout counter
`timescale 1ns/1ns
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin badCount++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_itc_timeout_counter;
    import itc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                clock;
    logic                rst;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                statusStrobe;
    logic [7:0]          statusCode;
    logic                sclDriveLow;
    logic                sdaDriveLow;
    logic                sclOut;
    logic                sclOe;
    logic                sdaOut;
    logic                sdaOe;
    logic [7:0]          serialClockRate;
    logic                serialFunctionEnable;
    logic                irq;
    int                  badCount;
    int                  checksDone;
    int                  n;
    logic [31:0]         rdv;
    logic                err;

    itc_timeout_counter dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .statusStrobe(statusStrobe), .statusCode(statusCode),
        .sclDriveLow(sclDriveLow), .sdaDriveLow(sdaDriveLow), .sclOut(sclOut), .sclOe(sclOe),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .serialClockRate(serialClockRate),
        .serialFunctionEnable(serialFunctionEnable), .irq(irq));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // Holds the request until pready is seen high; no fixed latency assumed
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
            if (k > 20) begin badCount++; close_out(); end
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdv, e)
    endtask : rd

    task automatic strobe(input logic [7:0] c);
        @(posedge clock);
        statusStrobe <= 1'b1; statusCode <= c;
        @(posedge clock);
        statusStrobe <= 1'b0;
    endtask : strobe

    // A used-up bound means the overflow never came: mismatch and stop
    task automatic wait_irq(input int maxCycles);
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clock);
            n++;
            if (n > maxCycles) begin badCount++; close_out(); end
        end
    endtask : wait_irq

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        badCount = 0; checksDone = 0;
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
        pwdata = '0; statusStrobe = 1'b0; statusCode = 8'h0;
        sclDriveLow = 1'b1; sdaDriveLow = 1'b0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(TIMEOUT_CTRL_ADDR, 32'h0);
        rd(CLOCK_RATE_ADDR, 32'h0);
        `CHK(irq, 1'b0)
        apb(1'b1, CLOCK_RATE_ADDR, 32'h0000_00a5);
        rd(CLOCK_RATE_ADDR, 32'h0000_00a5);
        `CHK(serialClockRate, 8'ha5)
        rd(12'h100, 32'h0);
        `CHK(err, 1'b1)
        strobe(IDLE_STATUS_CODE);
        rd(IRQ_STATUS_ADDR, 32'h0);
        strobe(8'h08);
        rd(SERIAL_CTRL_ADDR, 32'h0000_0008);
        rd(IRQ_STATUS_ADDR, 32'h0000_0002);
        apb(1'b1, IRQ_MASK_ADDR, 32'h2);
        rd(IRQ_MASK_ADDR, 32'h0000_0002);
        `CHK(irq, 1'b1)
        apb(1'b1, SERIAL_CTRL_ADDR, 32'h0);
        apb(1'b1, IRQ_STATUS_ADDR, 32'h3);
        apb(1'b1, IRQ_MASK_ADDR, 32'h1);
        apb(1'b1, TIMEOUT_CTRL_ADDR, 32'hff);
        rd(TIMEOUT_CTRL_ADDR, 32'h0000_0006);
        apb(1'b1, TIMEOUT_CTRL_ADDR, 32'hfd);
        rd(TIMEOUT_CTRL_ADDR, 32'h0000_0004);
        `CHK(sclOe, 1'b0)
        // Idle phases are caught later: any counting shortens the overflow time
        repeat (200) @(posedge clock);
        `CHK(irq, 1'b0)
        apb(1'b1, TIMEOUT_CTRL_ADDR, 32'h0);
        apb(1'b1, SERIAL_CTRL_ADDR, 32'h40);
        // The write lands at the edge the task returns on; look once it has settled
        @(negedge clock);
        `CHK(serialFunctionEnable, 1'b1)
        `CHK(sclOe, 1'b1)
        `CHK(sdaOe, 1'b0)
        `CHK(sclOut, 1'b0)
        `CHK(sdaOut, 1'b0)
        repeat (200) @(posedge clock);
        `CHK(irq, 1'b0)
        apb(1'b1, TIMEOUT_CTRL_ADDR, 32'h04);
        wait_irq(16500);
        `CHK((n >= 16380 && n <= 16390), 1'b1)
        rd(TIMEOUT_CTRL_ADDR, 32'h0000_0005);
        repeat (100) @(posedge clock);
        rd(TIMEOUT_CTRL_ADDR, 32'h0000_0005);
        apb(1'b1, TIMEOUT_CTRL_ADDR, 32'h04);
        apb(1'b1, IRQ_STATUS_ADDR, 32'h1);
        rd(TIMEOUT_CTRL_ADDR, 32'h0000_0004);
        `CHK(irq, 1'b0)
        strobe(8'h28);
        apb(1'b1, SERIAL_CTRL_ADDR, 32'h40);
        apb(1'b1, IRQ_STATUS_ADDR, 32'h2);
        wait_irq(16500);
        `CHK((n >= 16380 && n <= 16390), 1'b1)
        apb(1'b1, TIMEOUT_CTRL_ADDR, 32'h06);
        apb(1'b1, IRQ_STATUS_ADDR, 32'h1);
        strobe(8'h30);
        apb(1'b1, SERIAL_CTRL_ADDR, 32'h40);
        apb(1'b1, IRQ_STATUS_ADDR, 32'h2);
        `CHK(irq, 1'b0)
        wait_irq(65600);
        `CHK((n >= 65530 && n <= 65550), 1'b1)
        close_out();
    end
endmodule : tb_itc_timeout_counter
